//--- tcb_pkg.sv
// constants, field layout and carrier types of the timer b capture block
// assumes one word-wide wishbone register window, byte index times four
package tcb_pkg;

  // ----------------------------------------------------------------
  // register index (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRLA  = 6'h00;
  localparam logic [5:0] IDX_MODE_CONTROL_B  = 6'h01;
  localparam logic [5:0] IDX_EVENT_CONTROL = 6'h04;
  localparam logic [5:0] IDX_INTEN  = 6'h05;
  localparam logic [5:0] IDX_FLAGS  = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_CNT    = 6'h0a;
  localparam logic [5:0] IDX_COMPARE_VALUE_REGISTER   = 6'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE  = 0;
  localparam int BIT_MODE    = 0;
  localparam int BIT_PIN_EN  = 4;
  localparam int BIT_INIT    = 5;
  localparam int BIT_EVENT_LATCH_FLAG_EI = 0;
  localparam int BIT_EDGE    = 4;
  localparam int BIT_FILTER  = 6;
  localparam int BIT_IE      = 0;
  localparam int BIT_FLAG    = 0;
  localparam int BIT_RUN     = 0;

  // ----------------------------------------------------------------
  // reset values and filter length
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int          FILT_LEN = 4;

  // ----------------------------------------------------------------
  // timer modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_INT     = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_EVENT_LATCH_FLAG    = 3'h2;
  localparam logic [2:0] MODE_FRQ     = 3'h3;
  localparam logic [2:0] MODE_PW      = 3'h4;
  localparam logic [2:0] MODE_PERIOD_AND_WIDTH_MODE   = 3'h5;
  localparam logic [2:0] MODE_SINGLE  = 3'h6;
  localparam logic [2:0] MODE_EIGHT_BIT_PULSE_MODE    = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       init;
    logic       pin_en;
    logic [2:0] mode;
  } tcb_mode_control_b_t;

  typedef struct packed {
    logic filter;
    logic edge_sel;
    logic event_latch_flag_ei;
  } tcb_event_control_t;

  typedef enum logic [1:0] {
    FPW_IDLE,
    FPW_HIGH,
    FPW_LOW
  } tcb_fpw_t;

endpackage

//--- tcb_capture_ctrl.sv
// timer b capture/compare mode, event, output and flag control
// assumes event and port inputs are synchronous to clk_i
//
// Behaviour
// - output starts at the initial level bit
// - initial level ignored in eight_bit_pulse_mode and single-shot
// - pin enable swaps port value for waveform
// - three-bit field selects one of eight modes
// - filter bit inserts or bypasses noise stage
// - events act only while input enabled
// - interrupt enable gates the flag request
// - periodic and eight_bit_pulse_mode modes ignore edges
// - timeout edges start/stop; single-shot edge starts
// - capture mode edge copies counter, sets flag
// - frequency edge captures, restarts, sets flag
// - frequency mode restarts counting from zero
// - pulse-width: one edge clears, other captures
// - pulse-width capture keeps counter running
// - combined mode: clear, capture, then stop
// - int/timeout/single flag when counter hits top
// - eight_bit_pulse_mode flag when counter hits low byte
// - flag clears by write one or by compare read in modes 2-5
// - request stands while flag and enable set
// - eight_bit_pulse_mode low byte period, high byte duty
// - compare register is top in timer modes
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module tcb_capture_ctrl (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // event input and port pin
  input  wire logic        event_i,
  input  wire logic        port_out_i,
  output var  logic        pin_out_o,
  // interrupt request
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                 enable;
  tcb_pkg::tcb_mode_control_b_t  mode_control_b;
  tcb_pkg::tcb_event_control_t event_control;
  logic                 irq_en;
  logic                 flag;
  logic [15:0]          counter_value;
  logic [15:0]          compare_value_register;
  logic                 run;
  tcb_pkg::tcb_fpw_t    fpw;
  logic                 wave;
  logic [tcb_pkg::FILT_LEN-2:0] samp;
  logic                 filt_lvl;
  logic                 ev_prev;

  logic                 next_run;
  logic [15:0]          next_cnt;
  logic [15:0]          next_compare_value_register;
  tcb_pkg::tcb_fpw_t    next_fpw;
  logic                 flag_set;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd;
  logic [5:0] idx;
  logic       event_latch_flag_mode;
  logic       flag_clr;

  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i;
  assign rd  = acc && !wb_we_i;
  assign idx = wb_adr_i[7:2];
  assign event_latch_flag_mode = (mode_control_b.mode >= tcb_pkg::MODE_EVENT_LATCH_FLAG) &&
                     (mode_control_b.mode <= tcb_pkg::MODE_PERIOD_AND_WIDTH_MODE);

  assign flag_clr = (wr && idx == tcb_pkg::IDX_FLAGS && wb_sel_i[0] &&
                     wb_dat_i[tcb_pkg::BIT_FLAG]) ||
                    (rd && idx == tcb_pkg::IDX_COMPARE_VALUE_REGISTER && event_latch_flag_mode);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= 32'h0000_0000;
      if (idx == tcb_pkg::IDX_CTRLA) begin
        wb_dat_o[tcb_pkg::BIT_ENABLE] <= enable;
      end else if (idx == tcb_pkg::IDX_MODE_CONTROL_B) begin
        wb_dat_o[tcb_pkg::BIT_MODE +: 3] <= mode_control_b.mode;
        wb_dat_o[tcb_pkg::BIT_PIN_EN]    <= mode_control_b.pin_en;
        wb_dat_o[tcb_pkg::BIT_INIT]      <= mode_control_b.init;
      end else if (idx == tcb_pkg::IDX_EVENT_CONTROL) begin
        wb_dat_o[tcb_pkg::BIT_EVENT_LATCH_FLAG_EI] <= event_control.event_latch_flag_ei;
        wb_dat_o[tcb_pkg::BIT_EDGE]    <= event_control.edge_sel;
        wb_dat_o[tcb_pkg::BIT_FILTER]  <= event_control.filter;
      end else if (idx == tcb_pkg::IDX_INTEN) begin
        wb_dat_o[tcb_pkg::BIT_IE] <= irq_en;
      end else if (idx == tcb_pkg::IDX_FLAGS) begin
        wb_dat_o[tcb_pkg::BIT_FLAG] <= flag;
      end else if (idx == tcb_pkg::IDX_STATUS) begin
        wb_dat_o[tcb_pkg::BIT_RUN] <= run;
      end else if (idx == tcb_pkg::IDX_CNT) begin
        wb_dat_o[15:0] <= counter_value;
      end else if (idx == tcb_pkg::IDX_COMPARE_VALUE_REGISTER) begin
        wb_dat_o[15:0] <= compare_value_register;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= 1'b0;
      mode_control_b  <= '0;
      event_control <= '0;
      irq_en <= 1'b0;
    end else if (wr && wb_sel_i[0]) begin
      if (idx == tcb_pkg::IDX_CTRLA) begin
        enable <= wb_dat_i[tcb_pkg::BIT_ENABLE];
      end else if (idx == tcb_pkg::IDX_MODE_CONTROL_B) begin
        mode_control_b.mode   <= wb_dat_i[tcb_pkg::BIT_MODE +: 3];
        mode_control_b.pin_en <= wb_dat_i[tcb_pkg::BIT_PIN_EN];
        mode_control_b.init   <= wb_dat_i[tcb_pkg::BIT_INIT];
      end else if (idx == tcb_pkg::IDX_EVENT_CONTROL) begin
        event_control.event_latch_flag_ei  <= wb_dat_i[tcb_pkg::BIT_EVENT_LATCH_FLAG_EI];
        event_control.edge_sel <= wb_dat_i[tcb_pkg::BIT_EDGE];
        event_control.filter   <= wb_dat_i[tcb_pkg::BIT_FILTER];
      end else if (idx == tcb_pkg::IDX_INTEN) begin
        irq_en <= wb_dat_i[tcb_pkg::BIT_IE];
      end
    end
  end

  // ----------------------------------------------------------------
  // event path
  // ----------------------------------------------------------------
  logic [tcb_pkg::FILT_LEN-1:0] filt_win;
  logic ev_lvl;
  logic ev_rise;
  logic ev_fall;
  logic sel_edge;
  logic opp_edge;

  assign filt_win = {samp, event_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp     <= '0;
      filt_lvl <= 1'b0;
    end else begin
      samp <= filt_win[tcb_pkg::FILT_LEN-2:0];
      // four equal samples move the level
      if (&filt_win) begin
        filt_lvl <= 1'b1;
      end else if (~|filt_win) begin
        filt_lvl <= 1'b0;
      end
    end
  end

  assign ev_lvl = event_control.filter ? filt_lvl : event_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev <= 1'b0;
    end else begin
      ev_prev <= ev_lvl;
    end
  end

  assign ev_rise  = event_control.event_latch_flag_ei && ev_lvl && !ev_prev;
  assign ev_fall  = event_control.event_latch_flag_ei && !ev_lvl && ev_prev;
  assign sel_edge = event_control.edge_sel ? ev_fall : ev_rise;
  assign opp_edge = event_control.edge_sel ? ev_rise : ev_fall;

  // ----------------------------------------------------------------
  // counter, capture and run control
  // ----------------------------------------------------------------
  logic at_top;
  logic at_low;

  assign at_top = run && (counter_value == compare_value_register);
  assign at_low = run && (counter_value[7:0] == compare_value_register[7:0]);

  always_comb begin
    next_cnt  = run ? counter_value + 16'h0001 : counter_value;
    next_run  = run;
    next_compare_value_register = compare_value_register;
    next_fpw  = fpw;
    flag_set  = 1'b0;
    if (!enable) begin
      next_run = 1'b0;
      next_fpw = tcb_pkg::FPW_IDLE;
    end else begin
      case (mode_control_b.mode)
        tcb_pkg::MODE_INT: begin
          next_run = 1'b1;
          if (at_top) begin
            flag_set = 1'b1;
            next_cnt = 16'h0000;
          end
        end
        tcb_pkg::MODE_TIMEOUT: begin
          if (at_top) begin
            flag_set = 1'b1;
            next_cnt = 16'h0000;
          end
          if (sel_edge) begin
            next_run = 1'b1;
          end else if (opp_edge) begin
            next_run = 1'b0;
          end
        end
        tcb_pkg::MODE_EVENT_LATCH_FLAG: begin
          next_run = 1'b1;
          if (sel_edge) begin
            next_compare_value_register = counter_value;
            flag_set  = 1'b1;
          end
        end
        tcb_pkg::MODE_FRQ: begin
          next_run = 1'b1;
          if (sel_edge) begin
            next_compare_value_register = counter_value;
            flag_set  = 1'b1;
            next_cnt  = 16'h0000;
          end
        end
        tcb_pkg::MODE_PW: begin
          next_run = 1'b1;
          // clear on one edge, capture on other
          if (sel_edge) begin
            next_cnt = 16'h0000;
          end else if (opp_edge) begin
            next_compare_value_register = counter_value;
            flag_set  = 1'b1;
          end
        end
        tcb_pkg::MODE_PERIOD_AND_WIDTH_MODE: begin
          case (fpw)
            tcb_pkg::FPW_IDLE: begin
              if (sel_edge) begin
                next_cnt = 16'h0000;
                next_run = 1'b1;
                next_fpw = tcb_pkg::FPW_HIGH;
              end
            end
            tcb_pkg::FPW_HIGH: begin
              if (opp_edge) begin
                next_compare_value_register = counter_value;
                next_fpw  = tcb_pkg::FPW_LOW;
              end
            end
            default: begin
              if (sel_edge) begin
                next_run = 1'b0;
                next_cnt = counter_value;
                flag_set = 1'b1;
                next_fpw = tcb_pkg::FPW_IDLE;
              end
            end
          endcase
        end
        tcb_pkg::MODE_SINGLE: begin
          if (at_top) begin
            flag_set = 1'b1;
            next_run = 1'b0;
            next_cnt = 16'h0000;
          end else if (!run && sel_edge) begin
            next_run = 1'b1;
          end
        end
        default: begin
          next_run = 1'b1;
          next_cnt[15:8] = 8'h00;
          if (at_low) begin
            flag_set = 1'b1;
            next_cnt = 16'h0000;
          end
        end
      endcase
    end
  end

  // bus writes win over internal counter updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_value <= tcb_pkg::RST_WORD;
      run           <= 1'b0;
      fpw           <= tcb_pkg::FPW_IDLE;
    end else begin
      counter_value <= next_cnt;
      run           <= next_run;
      fpw           <= next_fpw;
      if (wr && idx == tcb_pkg::IDX_CNT) begin
        if (wb_sel_i[0]) begin
          counter_value[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          counter_value[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_register <= tcb_pkg::RST_WORD;
    end else begin
      compare_value_register <= next_compare_value_register;
      if (wr && idx == tcb_pkg::IDX_COMPARE_VALUE_REGISTER) begin
        if (wb_sel_i[0]) begin
          compare_value_register[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          compare_value_register[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flag and interrupt
  // ----------------------------------------------------------------
  // a set in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    end else if (flag_set) begin
      flag <= 1'b1;
    end else if (flag_clr) begin
      flag <= 1'b0;
    end
  end

  assign irq_o = flag && irq_en;

  // ----------------------------------------------------------------
  // waveform and pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave <= 1'b0;
    end else begin
      case (mode_control_b.mode)
        tcb_pkg::MODE_EIGHT_BIT_PULSE_MODE: begin
          wave <= counter_value[7:0] < compare_value_register[15:8];
        end
        tcb_pkg::MODE_SINGLE: begin
          wave <= next_run;
        end
        default: begin
          if (!enable) begin
            wave <= mode_control_b.init;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0;
    end else begin
      pin_out_o <= mode_control_b.pin_en ? wave : port_out_i;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic cnt_wr;
  assign cnt_wr = wr && idx == tcb_pkg::IDX_CNT;

  pin_mux_a: assert property (
    ##1 pin_out_o == $past(mode_control_b.pin_en ? wave : port_out_i))
    else $error("pin does not follow enable");

  init_level_a: assert property (
    mode_control_b.mode < tcb_pkg::MODE_SINGLE && !enable |=> wave == $past(mode_control_b.init))
    else $error("waveform not at initial level");

  event_gate_a: assert property (
    !event_control.event_latch_flag_ei |-> !ev_rise && !ev_fall)
    else $error("edge passed while input disabled");

  frq_capture_a: assert property (
    enable && mode_control_b.mode == tcb_pkg::MODE_FRQ && sel_edge && !wr
    |=> compare_value_register == $past(counter_value) && flag
        && counter_value == 16'h0000 ##1 counter_value == 16'h0001)
    else $error("frequency capture wrong");

  pw_keep_a: assert property (
    enable && mode_control_b.mode == tcb_pkg::MODE_PW && run && opp_edge && !cnt_wr
    |=> counter_value == $past(counter_value) + 16'h0001 && flag)
    else $error("pulse-width capture disturbed counter");

  top_flag_a: assert property (
    enable && mode_control_b.mode == tcb_pkg::MODE_INT && at_top |=> flag)
    else $error("no flag at top");

  pwm_flag_a: assert property (
    enable && mode_control_b.mode == tcb_pkg::MODE_EIGHT_BIT_PULSE_MODE && at_low |=> flag)
    else $error("no flag at period byte");

  flag_clear_a: assert property (
    flag_clr && !flag_set |=> !flag)
    else $error("flag not cleared");

  irq_hold_a: assert property (
    irq_o && !flag_clr |=> irq_o || !irq_en)
    else $error("request dropped while flag set");

  filter_hold_a: assert property (
    $past(event_control.filter) && filt_lvl != $past(filt_lvl)
    |-> $past(filt_win) == {tcb_pkg::FILT_LEN{filt_lvl}})
    else $error("filter passed a short level");

  periodic_edge_a: assert property (
    enable && mode_control_b.mode == tcb_pkg::MODE_INT |=> run)
    else $error("periodic mode stopped");

  frq_capture_c: cover property (
    enable && mode_control_b.mode == tcb_pkg::MODE_FRQ && sel_edge);
  period_and_width_mode_done_c: cover property (
    fpw == tcb_pkg::FPW_LOW && sel_edge ##1 flag);
  pwm_flag_c: cover property (
    mode_control_b.mode == tcb_pkg::MODE_EIGHT_BIT_PULSE_MODE && flag_set);
  filter_pass_c: cover property (
    event_control.filter && $changed(filt_lvl));

endmodule

`default_nettype wire

//--- tcb_event_model.sv
// event source and port pin on the far side of the timer b block
// assumes the bench calls its tasks from the clk_i domain
`timescale 1ns/1ns
`default_nettype none

module tcb_event_model (
  // clock
  input  wire logic clk_i,
  // event level and port output value
  output var  logic event_o,
  output var  logic port_o
);
  initial begin
    event_o = 1'b0;
    port_o  = 1'b0;
  end

  task automatic drive(input logic lvl, input int hold);
    @(posedge clk_i);
    event_o <= lvl;
    repeat (hold) @(posedge clk_i);
  endtask

  task automatic set_port(input logic v);
    @(posedge clk_i);
    port_o <= v;
  endtask
endmodule

`default_nettype wire

//--- test_tcb_capture_ctrl.sv
// self-checking bench of the timer b capture/compare control block
// assumes the event model drives event_i and port_out_i on clk_i edges
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end

module test_tcb_capture_ctrl;
  localparam logic [7:0] A_CTRLA  = {tcb_pkg::IDX_CTRLA, 2'b00};
  localparam logic [7:0] A_MODE_CONTROL_B  = {tcb_pkg::IDX_MODE_CONTROL_B, 2'b00};
  localparam logic [7:0] A_EVENT_CONTROL = {tcb_pkg::IDX_EVENT_CONTROL, 2'b00};
  localparam logic [7:0] A_INTEN  = {tcb_pkg::IDX_INTEN, 2'b00};
  localparam logic [7:0] A_FLAGS  = {tcb_pkg::IDX_FLAGS, 2'b00};
  localparam logic [7:0] A_STATUS = {tcb_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CNT    = {tcb_pkg::IDX_CNT, 2'b00};
  localparam logic [7:0] A_COMPARE_VALUE_REGISTER   = {tcb_pkg::IDX_COMPARE_VALUE_REGISTER, 2'b00};

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [31:0] cap;
  logic [3:0]  sel   = 4'h0;
  logic        we    = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic [31:0] dat_o;
  logic        ack;
  logic        ev;
  logic        port;
  logic        pin;
  logic        irq;
  int          num_errors = 0;
  int          samples_checked = 0;

  initial forever #10 clk_i = ~clk_i;

  tcb_capture_ctrl i_tcb_capture_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .event_i(ev), .port_out_i(port), .pin_out_o(pin), .irq_o(irq)
  );

  tcb_event_model i_tcb_event_model (.clk_i(clk_i), .event_o(ev), .port_o(port));

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // request held until ack is sampled, then released for a cycle
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    wdat <= d;
    we   <= w;
    sel  <= 4'hf;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    if (n >= 20) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    `CHK(nm, e, rdat)
  endtask

  task automatic ev_drv(input logic l, input int h);
    i_tcb_event_model.drive(l, h);
  endtask

  task automatic t_reset();
    rd_chk("mode_control_b rst", A_MODE_CONTROL_B, 32'h0);
    rd_chk("event_control rst", A_EVENT_CONTROL, 32'h0);
    rd_chk("inten rst", A_INTEN, 32'h0);
    rd_chk("flags rst", A_FLAGS, 32'h0);
    wr(8'h3c, 32'hff);
    rd_chk("unmapped", 8'h3c, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(A_MODE_CONTROL_B, 32'(m));
      rd_chk("mode field", A_MODE_CONTROL_B, 32'(m));
    end
    $display("t_reset done");
  endtask

  task automatic t_pin();
    wr(A_MODE_CONTROL_B, 32'h30);
    repeat (2) @(posedge clk_i);
    `CHK("pin init high", 1'b1, pin)
    wr(A_MODE_CONTROL_B, 32'h10);
    repeat (2) @(posedge clk_i);
    `CHK("pin init low", 1'b0, pin)
    i_tcb_event_model.set_port(1'b1);
    wr(A_MODE_CONTROL_B, 32'h20);
    repeat (2) @(posedge clk_i);
    `CHK("port value", 1'b1, pin)
    i_tcb_event_model.set_port(1'b0);
    // eight_bit_pulse_mode with duty zero stays low whatever the initial level
    wr(A_MODE_CONTROL_B, 32'h37);
    repeat (2) @(posedge clk_i);
    `CHK("eight_bit_pulse_mode init ignored", 1'b0, pin)
    $display("t_pin done");
  endtask

  task automatic t_capture();
    wr(A_MODE_CONTROL_B, 32'h02);
    wr(A_EVENT_CONTROL, 32'h01);
    wr(A_INTEN, 32'h01);
    wr(A_CNT, 32'h0);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 1);
    rd_chk("rise capture", A_FLAGS, 32'h1);
    `CHK("irq on flag", 1'b1, irq)
    bus(A_COMPARE_VALUE_REGISTER, 32'h0, 1'b0);
    `CHK("event_latch_flag value", 1'b1, rdat >= 32'h1 && rdat <= 32'h6)
    rd_chk("read clears", A_FLAGS, 32'h0);
    `CHK("irq drops", 1'b0, irq)
    wr(A_EVENT_CONTROL, 32'h11);
    ev_drv(1'b0, 1);
    rd_chk("fall capture", A_FLAGS, 32'h1);
    wr(A_INTEN, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    bus(A_COMPARE_VALUE_REGISTER, 32'h0, 1'b0);
    wr(A_EVENT_CONTROL, 32'h10);
    ev_drv(1'b1, 1);
    ev_drv(1'b0, 1);
    rd_chk("input off", A_FLAGS, 32'h0);
    wr(A_CTRLA, 32'h0);
    $display("t_capture done");
  endtask

  task automatic t_timeout();
    wr(A_MODE_CONTROL_B, 32'h01);
    wr(A_EVENT_CONTROL, 32'h01);
    wr(A_COMPARE_VALUE_REGISTER, 32'hffff);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 1);
    rd_chk("rise starts", A_STATUS, 32'h1);
    ev_drv(1'b0, 1);
    rd_chk("fall stops", A_STATUS, 32'h0);
    wr(A_EVENT_CONTROL, 32'h11);
    ev_drv(1'b1, 1);
    rd_chk("sel1 rise stops", A_STATUS, 32'h0);
    ev_drv(1'b0, 1);
    rd_chk("sel1 fall starts", A_STATUS, 32'h1);
    wr(A_CTRLA, 32'h0);
    $display("t_timeout done");
  endtask

  task automatic t_periodic();
    int n;
    wr(A_MODE_CONTROL_B, 32'h0);
    wr(A_EVENT_CONTROL, 32'h0);
    wr(A_INTEN, 32'h01);
    wr(A_COMPARE_VALUE_REGISTER, 32'h10);
    wr(A_CNT, 32'h0);
    wr(A_CTRLA, 32'h01);
    n = 0;
    while (irq !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("top reached", 1'b1, n >= 14 && n <= 18)
    wr(A_FLAGS, 32'h01);
    rd_chk("write one clears", A_FLAGS, 32'h0);
    wr(A_CTRLA, 32'h0);
    wr(A_INTEN, 32'h0);
    $display("t_periodic done");
  endtask

  task automatic t_eight_bit_pulse_mode();
    for (int i = 0; i < 2; i++) begin
      wr(A_MODE_CONTROL_B, i ? 32'h07 : 32'h00);
      wr(A_EVENT_CONTROL, 32'h01);
      wr(A_COMPARE_VALUE_REGISTER, 32'hffff);
      wr(A_CNT, 32'h0);
      wr(A_CTRLA, 32'h01);
      ev_drv(1'b1, 1);
      ev_drv(1'b0, 1);
      rd_chk("edges ignored", A_FLAGS, 32'h0);
      wr(A_CTRLA, 32'h0);
    end
    wr(A_COMPARE_VALUE_REGISTER, 32'h0008);
    wr(A_CNT, 32'h0);
    wr(A_CTRLA, 32'h01);
    rd_chk("before low byte", A_FLAGS, 32'h0);
    repeat (8) @(posedge clk_i);
    rd_chk("low byte top", A_FLAGS, 32'h1);
    wr(A_CTRLA, 32'h0);
    wr(A_FLAGS, 32'h01);
    $display("t_eight_bit_pulse_mode done");
  endtask

  task automatic t_freq();
    wr(A_MODE_CONTROL_B, 32'h03);
    wr(A_EVENT_CONTROL, 32'h01);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 2);
    ev_drv(1'b0, 5);
    ev_drv(1'b1, 2);
    bus(A_CNT, 32'h0, 1'b0);
    `CHK("restart at zero", 1'b1, rdat <= 32'h6)
    rd_chk("freq flag", A_FLAGS, 32'h1);
    bus(A_COMPARE_VALUE_REGISTER, 32'h0, 1'b0);
    `CHK("period capture", 1'b1, rdat >= 32'h8 && rdat <= 32'ha)
    rd_chk("freq read clears", A_FLAGS, 32'h0);
    ev_drv(1'b0, 1);
    wr(A_CTRLA, 32'h0);
    $display("t_freq done");
  endtask

  task automatic t_pw();
    wr(A_MODE_CONTROL_B, 32'h04);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 6);
    ev_drv(1'b0, 2);
    rd_chk("width flag", A_FLAGS, 32'h1);
    bus(A_COMPARE_VALUE_REGISTER, 32'h0, 1'b0);
    cap = rdat;
    `CHK("width capture", 1'b1, cap >= 32'h6 && cap <= 32'h8)
    bus(A_CNT, 32'h0, 1'b0);
    `CHK("keeps counting", 1'b1, rdat >= cap + 32'h6)
    wr(A_CTRLA, 32'h0);
    $display("t_pw done");
  endtask

  task automatic t_filter();
    wr(A_MODE_CONTROL_B, 32'h02);
    wr(A_EVENT_CONTROL, 32'h41);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 1);
    ev_drv(1'b0, 4);
    rd_chk("short pulse", A_FLAGS, 32'h0);
    ev_drv(1'b1, 6);
    rd_chk("long pulse", A_FLAGS, 32'h1);
    wr(A_CTRLA, 32'h0);
    $display("t_filter done");
  endtask

  task automatic t_period_and_width_mode();
    wr(A_MODE_CONTROL_B, 32'h05);
    wr(A_EVENT_CONTROL, 32'h01);
    ev_drv(1'b0, 1);
    wr(A_CTRLA, 32'h01);
    ev_drv(1'b1, 4);
    ev_drv(1'b0, 3);
    ev_drv(1'b1, 2);
    rd_chk("period_and_width_mode flag", A_FLAGS, 32'h1);
    rd_chk("period_and_width_mode stopped", A_STATUS, 32'h0);
    bus(A_COMPARE_VALUE_REGISTER, 32'h0, 1'b0);
    `CHK("period_and_width_mode width", 1'b1, rdat >= 32'h3 && rdat <= 32'h6)
    rd_chk("period_and_width_mode read clears", A_FLAGS, 32'h0);
    wr(A_CTRLA, 32'h0);
    $display("t_period_and_width_mode done");
  endtask

  task automatic t_single();
    wr(A_MODE_CONTROL_B, 32'h36);
    wr(A_COMPARE_VALUE_REGISTER, 32'h40);
    wr(A_CNT, 32'h0);
    ev_drv(1'b0, 1);
    wr(A_CTRLA, 32'h01);
    repeat (2) @(posedge clk_i);
    `CHK("single init ignored", 1'b0, pin)
    ev_drv(1'b1, 1);
    rd_chk("shot running", A_STATUS, 32'h1);
    `CHK("shot output high", 1'b1, pin)
    repeat (70) @(posedge clk_i);
    rd_chk("shot top flag", A_FLAGS, 32'h1);
    rd_chk("shot ended", A_STATUS, 32'h0);
    `CHK("shot output low", 1'b0, pin)
    wr(A_CTRLA, 32'h0);
    wr(A_FLAGS, 32'h01);
    $display("t_single done");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pin();
    t_capture();
    t_timeout();
    t_periodic();
    t_eight_bit_pulse_mode();
    t_freq();
    t_pw();
    t_filter();
    t_period_and_width_mode();
    t_single();
    tally_and_finish();
  end

  // whole run needs well under a thousand cycles
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
